//--- fade_pkg.sv
// constants, register map and carrier types for the duty fade engine
package fade_pkg;
	localparam logic [7:0] ADDR_DEVICE_CTRL = 8'h01;
	localparam logic [7:0] ADDR_DUTY_MSB    = 8'h03;
	localparam logic [7:0] ADDR_DUTY_LSB    = 8'h04;
	localparam logic [7:0] ADDR_PERIOD_DIV  = 8'h05;
	localparam logic [7:0] ADDR_RAMP_OPTS   = 8'h09;
	localparam logic [7:0] ADDR_RAMP_TICK   = 8'h0A;

	localparam int         BIT_FAST_PERIOD  = 5;
	localparam int         BIT_FADE_ON      = 7;
	localparam int         BIT_CURVE_LINEAR = 6;
	localparam int         SCALE_MSB        = 2;
	localparam int         TICK_MSB         = 6;
	localparam int         DUTY_MSB_BITS    = 2;

	localparam int         DUTY_W           = 10;
	localparam int         STEP_W           = 16;
	localparam int         PERIOD_W         = 18;
	localparam logic [2:0] SCALE_SAT_CODE   = 3'h4;
	localparam logic [2:0] SCALE_SAT_EXP    = 3'h5;
	localparam int         LOG_SHIFT        = 4;
	localparam int         SHORT_PERIOD     = 512;
	localparam int         LONG_PERIOD      = 1024;

	localparam logic [7:0] REG_RESET        = 8'h00;

	typedef struct packed {
		logic       fade_on;
		logic       curve_linear;
		logic [2:0] increment_scale;
	} fade_cfg_t;

	typedef struct packed {
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_t;
endpackage

//--- pwm_period_timer.sv
// pwm output period timer: one-cycle tick at the end of every period
`timescale 1ns/1ns
module pwm_period_timer
	import fade_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       fast_period,
	input  wire logic [7:0] period_div,
	output logic            period_tick
);
	logic [PERIOD_W-1:0] cnt_q, cnt_d;
	logic                tick_q, tick_d;
	logic [PERIOD_W-1:0] last_count;

	// settings are read live, so a change lands within the current period
	always_comb begin
		last_count = PERIOD_W'((fast_period ? SHORT_PERIOD : LONG_PERIOD) * (int'(period_div) + 1) - 1);
		tick_d     = 1'b0;
		cnt_d      = cnt_q + 1'b1;
		if (cnt_q >= last_count) begin
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign period_tick = tick_q;

	// assertion helper: clocks elapsed since the last tick
	logic [PERIOD_W-1:0] gap_q, gap_d;
	always_comb begin
		gap_d = tick_q ? PERIOD_W'(1) : gap_q + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_d;
		end
	end

	property p_period_len;
		@(posedge clk) disable iff (!rst_n)
		(tick_q |=> !tick_q) and
		($rose(tick_q) && $past(tick_q, 2) == 1'b0 && gap_q > 1 && $stable(period_div) && $stable(fast_period)
			|-> gap_q >= last_count + 1'b1);
	endproperty
	chk_period_length: assert property (p_period_len) else $error("pwm period shorter than divider setting");
endmodule

//--- pwm_duty_fade_engine.sv
// duty fade engine: register file, period-paced ramp of the applied duty toward its target
`timescale 1ns/1ns
// Operation
// - fade off: new duty applied at once; fade on: duty moves gradually
// - curve bit 0 gives logarithmic ramp, 1 gives linear ramp
// - each step is scaled by two to the N, N saturating at five
// - during a fade, update once every one plus tick-divider pwm periods
// - duty target is ten bits: two high bits, then eight low bits
// - pwm period is 512 or 1024 times divider plus one clocks
module pwm_duty_fade_engine
	import fade_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire reg_write_t        reg_wr,
	input  wire logic [7:0]        reg_rd_addr,
	output logic [7:0]             reg_rd_data,
	output logic [DUTY_W-1:0]      duty_applied,
	output logic                   fade_busy
);
	// reset asserts at once but releases two edges late, clear of any clock edge
	logic rst_meta_q, rst_sync_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	function automatic logic [2:0] scale_exp(input logic [2:0] code);
		scale_exp = (code > SCALE_SAT_CODE) ? SCALE_SAT_EXP : code;
	endfunction

	// log curve: step grows with the present duty, so equal steps look equal in brightness
	function automatic logic [STEP_W-1:0] step_size(input logic [DUTY_W-1:0] cur, input fade_cfg_t c);
		logic [STEP_W-1:0] base;
		base = c.curve_linear ? STEP_W'(1) : STEP_W'((cur >> LOG_SHIFT) + 1'b1);
		step_size = base << scale_exp(c.increment_scale);
	endfunction

	// register file
	logic [7:0] ctrl_q, ctrl_d, msb_q, msb_d, lsb_q, lsb_d, div_q, div_d, opts_q, opts_d, tick_q, tick_d;
	logic [7:0] rd_q, rd_d;

	always_comb begin
		ctrl_d = ctrl_q;
		msb_d  = msb_q;
		lsb_d  = lsb_q;
		div_d  = div_q;
		opts_d = opts_q;
		tick_d = tick_q;
		if (reg_wr.wr_en) begin
			case (reg_wr.addr)
				ADDR_DEVICE_CTRL: ctrl_d = reg_wr.data;
				ADDR_DUTY_MSB:    msb_d  = {6'h00, reg_wr.data[DUTY_MSB_BITS-1:0]};
				ADDR_DUTY_LSB:    lsb_d  = reg_wr.data;
				ADDR_PERIOD_DIV:  div_d  = reg_wr.data;
				ADDR_RAMP_OPTS:   opts_d = {reg_wr.data[BIT_FADE_ON:BIT_CURVE_LINEAR], 3'h0, reg_wr.data[SCALE_MSB:0]};
				ADDR_RAMP_TICK:   tick_d = {1'b0, reg_wr.data[TICK_MSB:0]};
				default: ;
			endcase
		end
		case (reg_rd_addr)
			ADDR_DEVICE_CTRL: rd_d = ctrl_q;
			ADDR_DUTY_MSB:    rd_d = msb_q;
			ADDR_DUTY_LSB:    rd_d = lsb_q;
			ADDR_PERIOD_DIV:  rd_d = div_q;
			ADDR_RAMP_OPTS:   rd_d = opts_q;
			ADDR_RAMP_TICK:   rd_d = tick_q;
			default:          rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctrl_q <= REG_RESET;
			msb_q  <= REG_RESET;
			lsb_q  <= REG_RESET;
			div_q  <= REG_RESET;
			opts_q <= REG_RESET;
			tick_q <= REG_RESET;
			rd_q   <= REG_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			msb_q  <= msb_d;
			lsb_q  <= lsb_d;
			div_q  <= div_d;
			opts_q <= opts_d;
			tick_q <= tick_d;
			rd_q   <= rd_d;
		end
	end

	fade_cfg_t         cfg;
	logic [DUTY_W-1:0] target;
	assign cfg    = '{fade_on: opts_q[BIT_FADE_ON], curve_linear: opts_q[BIT_CURVE_LINEAR],
	                  increment_scale: opts_q[SCALE_MSB:0]};
	assign target = {msb_q[DUTY_MSB_BITS-1:0], lsb_q};

	logic period_tick;
	pwm_period_timer u_period (
		.clk         (ref_clk),
		.rst_n       (rst_sync_q),
		.fast_period (ctrl_q[BIT_FAST_PERIOD]),
		.period_div  (div_q),
		.period_tick (period_tick)
	);

	// ramp state
	logic [DUTY_W-1:0] duty_q, duty_d;
	logic [6:0]        pcnt_q, pcnt_d;
	logic              busy_q, busy_d;
	logic              fade_step;
	logic [STEP_W-1:0] step, gap;

	always_comb begin
		step      = step_size(duty_q, cfg);
		gap       = (duty_q < target) ? STEP_W'(target - duty_q) : STEP_W'(duty_q - target);
		fade_step = 1'b0;
		pcnt_d    = pcnt_q;
		duty_d    = duty_q;
		// the interval count restarts while fading is off, but the period timer runs on, so the first step can come up to one period early
		if (!cfg.fade_on) begin
			duty_d = target;
			pcnt_d = '0;
		end else if (period_tick) begin
			if (pcnt_q >= tick_q[TICK_MSB:0]) begin
				pcnt_d    = '0;
				fade_step = 1'b1;
			end else begin
				pcnt_d = pcnt_q + 1'b1;
			end
		end
		if (fade_step && duty_q != target) begin
			if (gap <= step)
				duty_d = target;
			else if (duty_q < target)
				duty_d = duty_q + step[DUTY_W-1:0];
			else
				duty_d = duty_q - step[DUTY_W-1:0];
		end
		// busy follows the next duty, so it drops on the same edge that lands the fade
		busy_d = (duty_d != target);
	end

	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			duty_q <= '0;
			pcnt_q <= '0;
			busy_q <= 1'b0;
		end else begin
			duty_q <= duty_d;
			pcnt_q <= pcnt_d;
			busy_q <= busy_d;
		end
	end

	assign reg_rd_data  = rd_q;
	assign duty_applied = duty_q;
	assign fade_busy    = busy_q;

	sequence s_step_up_far;
		fade_step && duty_q < target && gap > step;
	endsequence
	sequence s_step_down_far;
		fade_step && duty_q > target && gap > step;
	endsequence
	sequence s_step_land;
		fade_step && duty_q != target && gap <= step;
	endsequence

	chk_jump_direct: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		!cfg.fade_on |=> duty_q == $past(target)) else $error("duty did not jump with fade off");
	chk_fade_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		cfg.fade_on && !fade_step |=> $stable(duty_q)) else $error("duty moved between fade updates");
	chk_step_pacing: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		fade_step |-> period_tick && pcnt_q == tick_q[TICK_MSB:0]) else $error("fade update off its period count");
	chk_linear_size: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		s_step_up_far and cfg.curve_linear |=> duty_q - $past(duty_q) == DUTY_W'(1 << scale_exp($past(opts_q[SCALE_MSB:0]))))
		else $error("linear step size wrong");
	chk_log_size: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		s_step_down_far and !cfg.curve_linear |=>
			$past(duty_q) - duty_q == DUTY_W'((($past(duty_q) >> LOG_SHIFT) + 1) << scale_exp($past(opts_q[SCALE_MSB:0]))))
		else $error("log step size wrong");
	chk_no_overshoot: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		fade_step && duty_q < target |=> duty_q <= $past(target) && duty_q > $past(duty_q))
		else $error("fade overshot target");
	chk_target_assemble: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		reg_wr.wr_en && reg_wr.addr == ADDR_DUTY_LSB && !cfg.fade_on ##1 !cfg.fade_on && !reg_wr.wr_en
		|=> duty_q == {$past(msb_q[DUTY_MSB_BITS-1:0], 2), $past(reg_wr.data, 2)})
		else $error("duty target assembled wrong");

	// mirror checks for the other direction and the bookkeeping around each update
	chk_linear_down: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		s_step_down_far and cfg.curve_linear |=>
			$past(duty_q) - duty_q == DUTY_W'(1 << scale_exp($past(opts_q[SCALE_MSB:0]))))
		else $error("linear step size wrong going down");
	chk_log_up: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		s_step_up_far and !cfg.curve_linear |=>
			duty_q - $past(duty_q) == DUTY_W'((($past(duty_q) >> LOG_SHIFT) + 1) << scale_exp($past(opts_q[SCALE_MSB:0]))))
		else $error("log step size wrong going up");
	chk_exact_land: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		s_step_land |=> duty_q == $past(target) && !busy_q) else $error("fade did not land on target");
	chk_busy_idle: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		!cfg.fade_on |=> !busy_q) else $error("busy raised with fading off");
	chk_count_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		!cfg.fade_on |=> pcnt_q == '0) else $error("interval count kept with fading off");
	chk_count_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		cfg.fade_on && !period_tick |=> $stable(pcnt_q)) else $error("interval count moved without a period tick");
	chk_step_enable: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		fade_step |-> cfg.fade_on) else $error("fade update with fading off");
	chk_rate_store: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		reg_wr.wr_en && reg_wr.addr == ADDR_RAMP_TICK |=> tick_q == {1'b0, $past(reg_wr.data[TICK_MSB:0])})
		else $error("tick divider not stored");
	chk_opts_store: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
		reg_wr.wr_en && reg_wr.addr == ADDR_RAMP_OPTS |=> cfg.curve_linear == $past(reg_wr.data[BIT_CURVE_LINEAR])
			&& cfg.fade_on == $past(reg_wr.data[BIT_FADE_ON])) else $error("fade options not stored");
endmodule

//--- fade_host_model.sv
// host-side model: register writes and reads over the strobe interface
`timescale 1ns/1ns
module fade_host_model
	import fade_pkg::*;
(
	input  wire logic       clk,
	output reg_write_t      reg_wr,
	output logic [7:0]      reg_rd_addr,
	input  wire logic [7:0] reg_rd_data
);
	initial begin
		reg_wr = '0;
		reg_rd_addr = 8'h00;
	end
	// released fields show inverted values so a stale address or data cannot pass for a real one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_wr = reg_write_t'{1'b1, a, d};
		@(posedge clk);
		#1 reg_wr = reg_write_t'{1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 reg_rd_addr = a;
		@(posedge clk);
		#1 d = reg_rd_data;
	endtask
endmodule

//--- pwm_duty_fade_engine_tb.sv
// self-checking bench for the duty fade engine
`timescale 1ns/1ns
module pwm_duty_fade_engine_tb;
	import fade_pkg::*;
	logic              ref_clk;
	logic              rst_b;
	reg_write_t        reg_wr;
	logic [7:0]        reg_rd_addr;
	logic [7:0]        reg_rd_data;
	logic [DUTY_W-1:0] duty_applied;
	logic              fade_busy;
	int                errors = 0;
	int                total_checks = 0;
	int                cycles = 0;
	logic [7:0]        rv;
	logic [7:0]        tab [0:4][0:2] = '{'{8'h09, 8'hFF, 8'hC7}, '{8'h0A, 8'hFF, 8'h7F},
		'{8'h0B, 8'hFF, 8'h00}, '{8'h09, 8'h5A, 8'h42}, '{8'h03, 8'hFF, 8'h03}};

	pwm_duty_fade_engine i_pwm_duty_fade_engine (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .duty_applied(duty_applied), .fade_busy(fade_busy));
	fade_host_model i_fade_host_model (.clk(ref_clk), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		if (errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a hang is cut short well beyond the longest fade scenario
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			close_out();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_fade_host_model.wr(a, d);
	endtask

	task automatic set_duty(input logic [DUTY_W-1:0] v);
		wr(ADDR_DUTY_MSB, {6'h00, v[9:8]});
		wr(ADDR_DUTY_LSB, v[7:0]);
	endtask

	task automatic wait_step(output int n);
		logic [DUTY_W-1:0] prev;
		prev = duty_applied;
		n = 0;
		while (duty_applied === prev && n < 5000) begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask

	function automatic int next_duty(input int d, input logic [7:0] o, input int t);
		int st;
		st = (o[6] ? 1 : (d >> 4) + 1) << ((o[2:0] > 3'h4) ? 5 : o[2:0]);
		if (t > d) return (d + st > t) ? t : d + st;
		return (d - st < t) ? t : d - st;
	endfunction

	// one or two steps from a known start; the first step's phase is free, the second gives the interval
	task automatic fade_case(input logic [7:0] o, input logic [7:0] tick, input int s, input int t, input int per);
		int n;
		int e;
		int d0;
		wr(ADDR_RAMP_OPTS, 8'h00);
		set_duty(s[9:0]);
		wr(ADDR_RAMP_TICK, tick);
		wr(ADDR_RAMP_OPTS, o);
		set_duty(t[9:0]);
		// a step may fall between the two target writes, so the first expectation starts where the duty stands
		d0 = int'(duty_applied);
		wait_step(n);
		e = next_duty(d0, o, t);
		check(duty_applied, e[9:0]);
		if (e != t) begin
			wait_step(n);
			e = next_duty(e, o, t);
			check(duty_applied, e[9:0]);
			check(n[15:0], 16'((tick + 1) * per));
		end
		repeat (2) @(posedge ref_clk);
		#1 check(fade_busy, e != t);
	endtask

	initial begin
		rst_b = 1'b0;
		repeat (12) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge ref_clk);
		i_fade_host_model.rd(ADDR_RAMP_OPTS, rv);
		check(rv, 8'h00);
		i_fade_host_model.rd(ADDR_RAMP_TICK, rv);
		check(rv, 8'h00);
		foreach (tab[i]) begin
			wr(tab[i][0], tab[i][1]);
			i_fade_host_model.rd(tab[i][0], rv);
			check(rv, tab[i][2]);
		end
		wr(ADDR_RAMP_OPTS, 8'h00);
		set_duty(10'h234);
		repeat (2) @(posedge ref_clk);
		#1 check(duty_applied, 10'h234);
		wr(ADDR_DEVICE_CTRL, 8'h20);
		wr(ADDR_PERIOD_DIV, 8'h00);
		fade_case(8'hC0, 8'h00, 'h100, 'h3FF, 512);
		fade_case(8'hC7, 8'h01, 'h000, 'h3FF, 512);
		fade_case(8'hC6, 8'h00, 'h000, 'h3FF, 512);
		fade_case(8'h82, 8'h00, 'h100, 'h3FF, 512);
		fade_case(8'hC4, 8'h02, 'h3FF, 'h000, 512);
		fade_case(8'hC2, 8'h00, 'h00E, 'h010, 512);
		wr(ADDR_PERIOD_DIV, 8'h01);
		fade_case(8'hC3, 8'h00, 'h000, 'h3FF, 1024);
		wr(ADDR_DEVICE_CTRL, 8'h00);
		wr(ADDR_PERIOD_DIV, 8'h00);
		fade_case(8'h81, 8'h00, 'h200, 'h000, 1024);
		close_out();
	end
endmodule
